/* inc/can_cfg_pkg.sv */
// constants shared by the buffer configuration and checking block
package can_cfg_pkg;
  // register bus geometry
  localparam int AW = 8;
  localparam int DW = 32;
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFS_MODE_STAT  = 8'h00;
  localparam logic [AW-1:0] OFS_RXBUF_CNT  = 8'h04;
  localparam logic [AW-1:0] OFS_RXF_CFG    = 8'h08;
  localparam logic [AW-1:0] OFS_CFF_CFG    = 8'h0C;
  localparam logic [AW-1:0] OFS_TXQ_CFG    = 8'h10;
  localparam logic [AW-1:0] OFS_GLB_CFG    = 8'h14;
  localparam logic [AW-1:0] OFS_PAIR_CFG   = 8'h18;
  localparam logic [AW-1:0] OFS_LEND_ALLOC = 8'h1C;
  localparam logic [AW-1:0] OFS_ERR_STAT   = 8'h20;
  // reset values
  localparam logic [DW-1:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0]    PIN_IDLE = 8'hFF;
  // receive fifo fields: depth[2:0] mode[3] thr[6:4] irq_en[7] enable[8]
  localparam logic [DW-1:0] RXF_GLB_MASK  = 32'h0000_007F;
  localparam logic [DW-1:0] RXF_IDLE_MASK = 32'h0000_0080;
  localparam logic [DW-1:0] RXF_FREE_MASK = 32'h0000_0100;
  localparam int            RXF_EN_BIT    = 8;
  // tx/rx fifo fields: depth[2:0] irqm[3] thr[6:4] op[8:7] link[13:9]
  // rx_ie[14] tx_ie[15] clk_sel[16] presc[17] interval[25:18] enable[26]
  localparam logic [DW-1:0] CFF_GLB_MASK  = 32'h0000_3FFF;
  localparam logic [DW-1:0] CFF_IDLE_MASK = 32'h03FF_C000;
  localparam logic [DW-1:0] CFF_FREE_MASK = 32'h0400_0000;
  localparam int            CFF_EN_BIT    = 26;
  // queue/history: depth[4:0] irqm[5] full_ie[6] ow_rx_ie[7] ow_tx_ie[8]
  // q_en[9] hist_src[10] hist_irqm[11] hist_en[12] hist_ie[13]
  localparam logic [DW-1:0] TXQ_CHR_MASK  = 32'h0000_0C3F;
  localparam logic [DW-1:0] TXQ_IDLE_MASK = 32'h0000_01C0;
  localparam logic [DW-1:0] HST_IDLE_MASK = 32'h0000_2000;
  localparam logic [DW-1:0] TXQ_FREE_MASK = 32'h0000_1200;
  localparam int            TXQ_EN_BIT    = 9;
  localparam int            HST_EN_BIT    = 12;
  // global config: prio[0] len_chk[1] err_ie[14:8]
  localparam int            GCF_LEN_BIT   = 1;
  localparam int            GCF_IE_LSB    = 8;
  // error flag positions
  localparam int ERR_N       = 7;
  localparam int ERR_LEN     = 0;
  localparam int ERR_FIFO    = 1;
  localparam int ERR_HIST    = 2;
  localparam int ERR_PAYLOAD = 3;
  localparam int ERR_TXQ_OW  = 4;
  localparam int ERR_TXQ_LOST = 5;
  localparam int ERR_GW_OW   = 6;
  // transmit buffer lending
  localparam logic [6:0] TXBUF_PER_CH  = 7'h40;
  localparam logic [3:0] LEND_MAX_CODE = 4'h8;
endpackage

/* inc/pin_sync_if.sv */
// bundle between the pin synchroniser and the block top
`timescale 1ns/1ps
interface pin_sync_if #(parameter int N = 8);
  logic [N-1:0] raw;    // pin levels straight from the pads
  logic [N-1:0] clean;  // levels after agreement filter
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface // pin_sync_if

/* rtl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   reset_n_in,
  // pin bundle
  pin_sync_if.sync    pins
);
  import can_cfg_pkg::*;
  // ==========================================================
  // stages
  logic [7:0] s1_q, s2_q, s3_q, cl_q; // chain and filtered level
  logic [7:0] s1_d, s2_d, s3_d, cl_d;

  // next values: stage one only feeds stage two
  always_comb begin
    s1_d = pins.raw;
    s2_d = s1_q;
    s3_d = s2_q;
    // a change counts only once stages two and three agree
    cl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & cl_q);
  end

  // registers start recessive so no false edge at release
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      cl_q <= PIN_IDLE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      cl_q <= cl_d;
    end
  end

  assign pins.clean = cl_q;
endmodule // pin_sync

/* rtl/can_buf_cfg_check.sv */
// buffer configuration, channel pairing and global error checking
`timescale 1ns/1ps
module can_buf_cfg_check (
  // clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_n_in,
  // register port
  input  wire logic [can_cfg_pkg::AW-1:0] reg_addr_in,
  input  wire logic [can_cfg_pkg::DW-1:0] reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [can_cfg_pkg::DW-1:0] reg_rdata_out,
  // operating modes
  input  wire logic                     glb_reset_mode_in,
  input  wire logic [7:0]               ch_reset_mode_in,
  // channel protocol side
  input  wire logic [7:0]               ch_tx_in,
  input  wire logic [7:0]               ch_ack_in,
  input  wire logic [7:0]               ch_tx_active_in,
  output logic      [7:0]               ch_rx_out,
  // transceiver pins
  input  wire logic [7:0]               bus_rx_pin_in,
  output logic      [7:0]               bus_tx_pin_out,
  // buffer availability and lending
  output logic                          rx_buf_avail_out,
  output logic                          rx_fifo_usable_out,
  output logic                          txrx_fifo_usable_out,
  output logic                          txq_avail_out,
  output logic      [27:0]              tx_buf_total_out,
  output logic      [3:0]               lent_avail_out,
  // transmit buffer interrupts
  input  wire logic [7:0]               txbuf_irq_in,
  input  wire logic [3:0]               lent_irq_in,
  output logic      [7:0]               ch_txbuf_irq_out,
  // error event sources
  input  wire logic                     filt_pass_in,
  input  wire logic [3:0]               msg_len_code_in,
  input  wire logic [3:0]               rule_len_code_in,
  input  wire logic                     fifo_store_in,
  input  wire logic                     fifo_full_in,
  input  wire logic                     hist_store_in,
  input  wire logic                     hist_full_in,
  input  wire logic                     frame_store_in,
  input  wire logic [6:0]               payload_len_in,
  input  wire logic [6:0]               dest_size_in,
  input  wire logic                     txq_overwrite_in,
  input  wire logic                     txq_store_in,
  input  wire logic                     txq_full_in,
  input  wire logic                     gw_overwrite_in,
  output logic                          err_irq_out
);
  import can_cfg_pkg::*;

  // ==========================================================
  // helpers
  // masked field update: only bits in mask take the new value
  function automatic logic [DW-1:0] upd(input logic [DW-1:0] o,
      input logic [DW-1:0] n, input logic [DW-1:0] m);
    upd = (o & ~m) | (n & m);
  endfunction

  // lent buffer count; codes above the top one lend nothing
  function automatic logic [6:0] lend_cnt(input logic [3:0] c);
    lend_cnt = (c > LEND_MAX_CODE) ? 7'h00 : {1'b0, c, 2'b00};
  endfunction

  // ==========================================================
  // pin synchroniser
  pin_sync_if #(.N(8)) rxp ();
  assign rxp.raw = bus_rx_pin_in;
  pin_sync u_sync (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .pins        (rxp)
  );

  // ==========================================================
  // configuration registers
  logic [7:0]    rxcnt_q, rxcnt_d;   // rx buffer count
  logic [DW-1:0] rxf_q, rxf_d;       // rx fifo config
  logic [DW-1:0] cff_q, cff_d;       // tx/rx fifo config
  logic [DW-1:0] txq_q, txq_d;       // queue and history config
  logic [DW-1:0] gcf_q, gcf_d;       // global config
  logic [3:0]    pair_q, pair_d;     // pair enables
  logic [15:0]   lend_q, lend_d;     // four lending codes
  logic          wr_rxc, wr_rxf, wr_cff, wr_txq, wr_gcf, wr_par, wr_lnd;

  // write decode
  always_comb begin
    wr_rxc = reg_wr_in && (reg_addr_in == OFS_RXBUF_CNT);
    wr_rxf = reg_wr_in && (reg_addr_in == OFS_RXF_CFG);
    wr_cff = reg_wr_in && (reg_addr_in == OFS_CFF_CFG);
    wr_txq = reg_wr_in && (reg_addr_in == OFS_TXQ_CFG);
    wr_gcf = reg_wr_in && (reg_addr_in == OFS_GLB_CFG);
    wr_par = reg_wr_in && (reg_addr_in == OFS_PAIR_CFG);
    wr_lnd = reg_wr_in && (reg_addr_in == OFS_LEND_ALLOC);
  end

  // next config; fields outside their legal mode keep their value,
  // which protects live buffers from a stray write
  always_comb begin
    rxcnt_d = rxcnt_q;
    rxf_d   = rxf_q;
    cff_d   = cff_q;
    txq_d   = txq_q;
    gcf_d   = gcf_q;
    pair_d  = pair_q;
    lend_d  = lend_q;
    if (wr_rxc && glb_reset_mode_in) begin
      rxcnt_d = reg_wdata_in[7:0];
    end
    if (wr_rxf) begin
      if (glb_reset_mode_in) begin
        rxf_d = upd(rxf_d, reg_wdata_in, RXF_GLB_MASK);
      end
      if (!rxf_q[RXF_EN_BIT]) begin
        rxf_d = upd(rxf_d, reg_wdata_in, RXF_IDLE_MASK);
      end
      rxf_d = upd(rxf_d, reg_wdata_in, RXF_FREE_MASK);
    end
    if (wr_cff) begin
      if (glb_reset_mode_in) begin
        cff_d = upd(cff_d, reg_wdata_in, CFF_GLB_MASK);
      end
      if (!cff_q[CFF_EN_BIT]) begin
        cff_d = upd(cff_d, reg_wdata_in, CFF_IDLE_MASK);
      end
      cff_d = upd(cff_d, reg_wdata_in, CFF_FREE_MASK);
    end
    if (wr_txq) begin
      // queue and history belong to channel zero
      if (ch_reset_mode_in[0]) begin
        txq_d = upd(txq_d, reg_wdata_in, TXQ_CHR_MASK);
      end
      if (!txq_q[TXQ_EN_BIT]) begin
        txq_d = upd(txq_d, reg_wdata_in, TXQ_IDLE_MASK);
      end
      if (!txq_q[HST_EN_BIT]) begin
        txq_d = upd(txq_d, reg_wdata_in, HST_IDLE_MASK);
      end
      txq_d = upd(txq_d, reg_wdata_in, TXQ_FREE_MASK);
    end
    if (wr_gcf) begin
      gcf_d = reg_wdata_in;
    end
    // separate registers, so lending and pairing never share a write
    if (wr_par) begin
      pair_d = reg_wdata_in[3:0];
    end
    if (wr_lnd) begin
      lend_d = reg_wdata_in[15:0];
    end
  end

  // config registers
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxcnt_q <= RST_ZERO[7:0];
      rxf_q   <= RST_ZERO;
      cff_q   <= RST_ZERO;
      txq_q   <= RST_ZERO;
      gcf_q   <= RST_ZERO;
      pair_q  <= RST_ZERO[3:0];
      lend_q  <= RST_ZERO[15:0];
    end else begin
      rxcnt_q <= rxcnt_d;
      rxf_q   <= rxf_d;
      cff_q   <= cff_d;
      txq_q   <= txq_d;
      gcf_q   <= gcf_d;
      pair_q  <= pair_d;
      lend_q  <= lend_d;
    end
  end

  // ==========================================================
  // pairing, pins, lending and status outputs
  logic [7:0]  drv;                   // per-channel drive after ack block
  logic [7:0]  btx_q, btx_d, crx_q, crx_d, tirq_q, tirq_d;
  logic [27:0] tot_q, tot_d;
  logic [3:0]  lav_q, lav_d;
  logic [3:0]  av_q, av_d;            // rxbuf, rxfifo, txrx fifo, queue

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      // ack is held recessive while the partner sends
      drv[c] = (ch_ack_in[c] && pair_q[c/2] && ch_tx_active_in[c^1])
               ? 1'b1 : ch_tx_in[c];
    end
    for (int p = 0; p < 4; p++) begin
      // paired: even pin carries both channels wire-and, odd pin stays recessive; unpaired: each pin carries its own channel
      btx_d[2*p]   = drv[2*p] & (pair_q[p] ? drv[2*p+1] : 1'b1);
      btx_d[2*p+1] = pair_q[p] ? 1'b1 : drv[2*p+1];
      crx_d[2*p]   = rxp.clean[2*p];
      crx_d[2*p+1] = pair_q[p] ? rxp.clean[2*p] : rxp.clean[2*p+1];
      // odd channel lends; its mode governs the lent block
      lav_d[p] = pair_q[p] && !ch_reset_mode_in[2*p+1]
                 && (lend_cnt(lend_q[4*p +: 4]) != 7'h00);
      tot_d[7*p +: 7] = TXBUF_PER_CH
                 + (lav_d[p] ? lend_cnt(lend_q[4*p +: 4]) : 7'h00);
      tirq_d[2*p]   = txbuf_irq_in[2*p];
      tirq_d[2*p+1] = txbuf_irq_in[2*p+1]
                      | (pair_q[p] & lent_irq_in[p]);
    end
    av_d[0] = (rxcnt_q != 8'h00);
    av_d[1] = (rxf_q[2:0] != 3'h0);
    av_d[2] = (cff_q[2:0] != 3'h0);
    av_d[3] = (txq_q[4:0] != 5'h00);
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      btx_q  <= PIN_IDLE;
      crx_q  <= PIN_IDLE;
      tirq_q <= RST_ZERO[7:0];
      tot_q  <= RST_ZERO[27:0];
      lav_q  <= RST_ZERO[3:0];
      av_q   <= RST_ZERO[3:0];
    end else begin
      btx_q  <= btx_d;
      crx_q  <= crx_d;
      tirq_q <= tirq_d;
      tot_q  <= tot_d;
      lav_q  <= lav_d;
      av_q   <= av_d;
    end
  end

  // ==========================================================
  // global error flags
  logic [ERR_N-1:0] err_q, err_d, set_v, clr_v;
  logic             irq_q, irq_d;

  // set wins over a same-cycle write-one-to-clear
  always_comb begin
    set_v = '0;
    set_v[ERR_LEN] = gcf_q[GCF_LEN_BIT] && filt_pass_in
                     && (msg_len_code_in < rule_len_code_in);
    set_v[ERR_FIFO]     = fifo_store_in && fifo_full_in;
    set_v[ERR_HIST]     = hist_store_in && hist_full_in;
    set_v[ERR_PAYLOAD]  = frame_store_in
                          && (payload_len_in > dest_size_in);
    set_v[ERR_TXQ_OW]   = txq_overwrite_in;
    set_v[ERR_TXQ_LOST] = txq_store_in && txq_full_in;
    set_v[ERR_GW_OW]    = gw_overwrite_in;
    clr_v = (reg_wr_in && reg_addr_in == OFS_ERR_STAT)
            ? reg_wdata_in[ERR_N-1:0] : '0;
    err_d = (err_q & ~clr_v) | set_v;
    irq_d = |(err_d & gcf_d[GCF_IE_LSB +: ERR_N]);
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      err_q <= RST_ZERO[ERR_N-1:0];
      irq_q <= 1'b0;
    end else begin
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // read path: data stand in the cycle after the strobe only
  logic [DW-1:0] rd_q, rd_d;
  always_comb begin
    rd_d = '0;
    if (!reg_rd_in) begin
      rd_d = '0;
    end else if (reg_addr_in == OFS_MODE_STAT) begin
      rd_d = {20'h0, ch_reset_mode_in, av_q};
    end else if (reg_addr_in == OFS_RXBUF_CNT) begin
      rd_d = {24'h0, rxcnt_q};
    end else if (reg_addr_in == OFS_RXF_CFG) begin
      rd_d = rxf_q;
    end else if (reg_addr_in == OFS_CFF_CFG) begin
      rd_d = cff_q;
    end else if (reg_addr_in == OFS_TXQ_CFG) begin
      rd_d = txq_q;
    end else if (reg_addr_in == OFS_GLB_CFG) begin
      rd_d = gcf_q;
    end else if (reg_addr_in == OFS_PAIR_CFG) begin
      rd_d = {28'h0, pair_q};
    end else if (reg_addr_in == OFS_LEND_ALLOC) begin
      rd_d = {16'h0, lend_q};
    end else if (reg_addr_in == OFS_ERR_STAT) begin
      rd_d = {25'h0, err_q};
    end else begin
      rd_d = '0; // unmapped reads as zero
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_q <= RST_ZERO;
    end else begin
      rd_q <= rd_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out        = rd_q;
  assign bus_tx_pin_out       = btx_q;
  assign ch_rx_out            = crx_q;
  assign ch_txbuf_irq_out     = tirq_q;
  assign tx_buf_total_out     = tot_q;
  assign lent_avail_out       = lav_q;
  assign rx_buf_avail_out     = av_q[0];
  assign rx_fifo_usable_out   = av_q[1];
  assign txrx_fifo_usable_out = av_q[2];
  assign txq_avail_out        = av_q[3];
  assign err_irq_out          = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_rxbuf_zero: assert property (rxcnt_q == 8'h00 |=> !rx_buf_avail_out)
    else $error("rx buffers available with zero count");
  chk_fifo_depth: assert property (rxf_q[2:0] == 3'h0 |=> !rx_fifo_usable_out)
    else $error("rx fifo usable with zero depth");
  chk_txq_depth: assert property (txq_q[4:0] == 5'h00 |=> !txq_avail_out)
    else $error("queue available with zero depth");
  chk_odd_pin: assert property (pair_q[0] |=> bus_tx_pin_out[1])
    else $error("odd pin driven while paired");
  chk_ack_block: assert property (pair_q[0] && ch_tx_active_in[1] && ch_ack_in[0]
      && ch_tx_in[1] |=> bus_tx_pin_out[0])
    else $error("ack driven while partner transmits");
  chk_lend_total: assert property (pair_q[0] && !ch_reset_mode_in[1]
      && lend_q[3:0] == LEND_MAX_CODE |=> tx_buf_total_out[6:0] == 7'h60)
    else $error("lent total wrong");
  chk_lend_reset: assert property (ch_reset_mode_in[1] |=> !lent_avail_out[0])
    else $error("lent buffers live while lender in reset");
  chk_err_set: assert property (|set_v |=> (err_q & $past(set_v)) == $past(set_v))
    else $error("error event not flagged");
  chk_err_sticky: assert property (##1 ((err_q & $past(err_q & ~clr_v))
      == $past(err_q & ~clr_v)))
    else $error("error flag dropped without clear");
  chk_err_irq: assert property (err_irq_out == |(err_q & gcf_q[GCF_IE_LSB +: ERR_N]))
    else $error("error irq mismatch");
endmodule // can_buf_cfg_check

/* tb/can_bus_nodes.sv */
// far-side model: transceiver loop-back onto a wired-and bus per channel
`timescale 1ns/1ps
module can_bus_nodes (
  // device side pins, 1 recessive
  input  wire logic [7:0] tx_pin_in,
  // drive of the other nodes, 0 dominant
  input  wire logic [7:0] node_drive_in,
  // level seen by the transceiver receiver
  output logic      [7:0] rx_pin_out
);
  // ====================================================================
  // bus level
  // any dominant node wins, so the device hears its own bits too
  assign rx_pin_out = tx_pin_in & node_drive_in;
endmodule // can_bus_nodes

/* tb/can_buf_cfg_check_bench.sv */
// self-checking bench for the buffer configuration and checking block
`timescale 1ns/1ps
module can_buf_cfg_check_bench;
  import can_cfg_pkg::*;
  // one table row: address, write data, readback, availability
  typedef struct packed {
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    logic [DW-1:0] e;
    logic [3:0]    v;
  } row_t;
  logic          clk, rst_n, wr, rd, glb, err_irq;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [7:0]    ch_rst, tx, ack, act, rx, pin_tx, pin_rx, node_drv, own_irq, irq_out;
  logic [3:0]    avail, lent, lent_irq, mlen, rlen;
  logic [27:0]   total;
  logic          filt, fst, ffl, hst, hfl, frs, qow, qst, qfl, gow;
  logic [6:0]    plen, dsize;
  int            fails, compares;
  row_t          rows [13];
  // ====================================================================
  // design and far side
  can_buf_cfg_check i_dut (
    .core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .glb_reset_mode_in(glb),
    .ch_reset_mode_in(ch_rst), .ch_tx_in(tx), .ch_ack_in(ack), .ch_tx_active_in(act),
    .ch_rx_out(rx), .bus_rx_pin_in(pin_rx), .bus_tx_pin_out(pin_tx),
    .rx_buf_avail_out(avail[0]), .rx_fifo_usable_out(avail[1]),
    .txrx_fifo_usable_out(avail[2]), .txq_avail_out(avail[3]), .tx_buf_total_out(total),
    .lent_avail_out(lent), .txbuf_irq_in(own_irq), .lent_irq_in(lent_irq),
    .ch_txbuf_irq_out(irq_out), .filt_pass_in(filt), .msg_len_code_in(mlen),
    .rule_len_code_in(rlen), .fifo_store_in(fst), .fifo_full_in(ffl), .hist_store_in(hst),
    .hist_full_in(hfl), .frame_store_in(frs), .payload_len_in(plen), .dest_size_in(dsize),
    .txq_overwrite_in(qow), .txq_store_in(qst), .txq_full_in(qfl),
    .gw_overwrite_in(gow), .err_irq_out(err_irq));
  can_bus_nodes i_bus (.tx_pin_in(pin_tx), .node_drive_in(node_drv), .rx_pin_out(pin_rx));
  // ====================================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // the whole run needs well under two thousand cycles
  initial begin
    #(10000 * 5);
    fails++;
    give_verdict();
  end
  // ====================================================================
  // shared tasks
  task automatic check(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(n, rdata, e);
  endtask
  task automatic pin_case(input logic [3:0] p, input logic [7:0] t, input logic [7:0] k,
                          input logic [7:0] v, input logic [7:0] e);
    wr_reg(OFS_PAIR_CFG, {28'h0, p});
    tx  <= t;
    ack <= k;
    act <= v;
    repeat (3) @(posedge clk);
    #1 check("tx pins", {24'h0, pin_tx}, {24'h0, e});
  endtask
  // one event pulse, then flag, interrupt and clear are checked
  task automatic ev(input int k, input logic hit, input logic flag, input logic irq);
    @(posedge clk);
    filt <= (k == ERR_LEN);
    mlen <= hit ? 4'h3 : 4'h5;
    fst  <= (k == ERR_FIFO);
    ffl  <= hit;
    hst  <= (k == ERR_HIST);
    hfl  <= hit;
    frs  <= (k == ERR_PAYLOAD);
    plen <= hit ? 7'h41 : 7'h40;
    qow  <= (k == ERR_TXQ_OW) && hit;
    qst  <= (k == ERR_TXQ_LOST);
    qfl  <= hit;
    gow  <= (k == ERR_GW_OW) && hit;
    @(posedge clk);
    {filt, fst, ffl, hst, hfl, frs, qow, qst, qfl, gow} <= 10'h000;
    #1 check("error irq", {31'h0, err_irq}, {31'h0, irq});
    rd_chk("error flags", OFS_ERR_STAT, flag ? (32'h1 << k) : 32'h0);
    wr_reg(OFS_ERR_STAT, 32'h0000_007F);
    #1 check("irq cleared", {31'h0, err_irq}, 32'h0);
  endtask
  // ====================================================================
  // main sequence
  initial begin
    {rst_n, wr, rd, ack, act, own_irq, lent_irq, mlen, plen, addr, wdata} = '0;
    {filt, fst, ffl, hst, hfl, frs, qow, qst, qfl, gow} = '0;
    {tx, node_drv, ch_rst} = {8'hFF, 8'hFF, 8'hFF};
    glb   = 1'b1;
    rlen  = 4'h5;
    dsize = 7'h40;
    rows = '{'{OFS_RXBUF_CNT, 32'h80, 32'h80, 4'h1},
             '{OFS_RXF_CFG, 32'h71, 32'h71, 4'h3},
             '{OFS_CFF_CFG, 32'h1E71, 32'h1E71, 4'h7},
             '{OFS_TXQ_CFG, 32'hC3F, 32'hC3F, 4'hF},
             '{OFS_GLB_CFG, 32'h7F02, 32'h7F02, 4'hF},
             '{OFS_PAIR_CFG, 32'hF, 32'hF, 4'hF},
             '{OFS_LEND_ALLOC, 32'h0, 32'h0, 4'hF},
             '{8'h24, 32'hFFFF_FFFF, 32'h0, 4'hF},
             '{OFS_ERR_STAT, 32'h0, 32'h0, 4'hF},
             '{OFS_RXBUF_CNT, 32'h0, 32'h0, 4'hE},
             '{OFS_RXF_CFG, 32'h0, 32'h0, 4'hC},
             '{OFS_CFF_CFG, 32'h0, 32'h0, 4'h8},
             '{OFS_TXQ_CFG, 32'h0, 32'h0, 4'h0}};
    repeat (12) @(posedge clk);
    #1 check("reset pins", {16'h0, pin_tx, rx}, {16'h0, PIN_IDLE, PIN_IDLE});
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("reset total", {4'h0, total}, {4'h0, {4{TXBUF_PER_CH}}});
    for (int i = 0; i < 13; i++) begin
      if (i == 9) begin
        rd_chk("mode status", OFS_MODE_STAT, 32'hFFF);
        @(posedge clk);
        glb    <= 1'b0;
        ch_rst <= 8'h00;
        wr_reg(OFS_RXBUF_CNT, 32'h10);
        rd_chk("rx count kept", OFS_RXBUF_CNT, 32'h80);
        wr_reg(OFS_RXF_CFG, 32'h180);
        rd_chk("rx fifo on", OFS_RXF_CFG, 32'h1F1);
        wr_reg(OFS_RXF_CFG, 32'h0);
        rd_chk("rx fifo off", OFS_RXF_CFG, 32'hF1);
        wr_reg(OFS_CFF_CFG, 32'h0400_C000);
        rd_chk("txrx fifo on", OFS_CFF_CFG, 32'h0400_DE71);
        wr_reg(OFS_CFF_CFG, 32'h0);
        rd_chk("txrx fifo off", OFS_CFF_CFG, 32'hDE71);
        wr_reg(OFS_TXQ_CFG, 32'h3C0);
        rd_chk("queue on", OFS_TXQ_CFG, 32'hFFF);
        wr_reg(OFS_TXQ_CFG, 32'h0);
        rd_chk("queue off", OFS_TXQ_CFG, 32'hDFF);
        glb    <= 1'b1;
        ch_rst <= 8'hFF;
      end
      wr_reg(rows[i].a, rows[i].d);
      rd_chk("row readback", rows[i].a, rows[i].e);
      check("row avail", {28'h0, avail}, {28'h0, rows[i].v});
    end
    pin_case(4'hF, 8'hFD, 8'h00, 8'h00, 8'hFE);
    pin_case(4'h0, 8'hFD, 8'h00, 8'h00, 8'hFD);
    pin_case(4'hF, 8'hFE, 8'h01, 8'h02, 8'hFF);
    pin_case(4'hF, 8'hFE, 8'h01, 8'h00, 8'hFE);
    pin_case(4'hF, 8'hFF, 8'h00, 8'h00, 8'hFF);
    node_drv <= 8'hFE;
    repeat (8) @(posedge clk);
    #1 check("rx paired", {24'h0, rx}, 32'hFC);
    wr_reg(OFS_PAIR_CFG, 32'h0);
    repeat (8) @(posedge clk);
    #1 check("rx single", {24'h0, rx}, 32'hFE);
    node_drv <= 8'hFF;
    wr_reg(OFS_PAIR_CFG, 32'hF);
    ch_rst <= 8'h00;
    for (int c = 0; c < 10; c++) begin
      wr_reg(OFS_LEND_ALLOC, {16'h0, {4{4'(c)}}});
      repeat (2) @(posedge clk);
      #1 check("buffer total", {4'h0, total},
               {4'h0, {4{(c <= 8) ? TXBUF_PER_CH + 7'(4 * c) : TXBUF_PER_CH}}});
      check("lent avail", {28'h0, lent}, (c > 0 && c <= 8) ? 32'hF : 32'h0);
    end
    wr_reg(OFS_LEND_ALLOC, 32'h8888);
    ch_rst   <= 8'hAA;
    lent_irq <= 4'hF;
    repeat (3) @(posedge clk);
    #1 check("lender reset", {28'h0, lent}, 32'h0);
    check("lent irq", {24'h0, irq_out}, 32'hAA);
    wr_reg(OFS_PAIR_CFG, 32'h0);
    own_irq <= 8'h55;
    repeat (3) @(posedge clk);
    #1 check("own irq", {24'h0, irq_out}, 32'h55);
    for (int k = 0; k < ERR_N; k++) ev(k, 1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) ev(k, 1'b0, 1'b0, 1'b0);
    wr_reg(OFS_GLB_CFG, 32'h7F00);
    ev(ERR_LEN, 1'b1, 1'b0, 1'b0);
    wr_reg(OFS_GLB_CFG, 32'h0002);
    ev(ERR_FIFO, 1'b1, 1'b1, 1'b0);
    // mid-run reset: pins go recessive, status and config drop to zero
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 check("mid reset", {20'h0, pin_tx, avail}, {20'h0, PIN_IDLE, 4'h0});
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("reset config", OFS_RXF_CFG, 32'h0);
    give_verdict();
  end
endmodule // can_buf_cfg_check_bench
